// [rtl/upc_cfg.svh]
/*
 * Constants of the port power mode controller: register offsets, field
 * positions, reset values and start-up counts.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef UPC_CFG_SVH
`define UPC_CFG_SVH

// ==========================================================================
// Register byte offsets on the Avalon-MM slave
`define UPC_OFS_PIN_STATE   4'h0
`define UPC_OFS_OVERRIDE    4'h4
`define UPC_OFS_ILIM_MAX    4'h8
`define UPC_OFS_ILIM_REQ    4'hc
`define UPC_ADDR_W          4

// ==========================================================================
// Field positions
`define UPC_PIN_PORT_POWER_ENABLE      0
`define UPC_PIN_MODE1       1
`define UPC_PIN_MODE2       2
`define UPC_PIN_EMU_EN      3
`define UPC_PIN_POLARITY    4
`define UPC_PIN_ATTACH      5
`define UPC_PIN_ALERT       6
`define UPC_PIN_W           7
`define UPC_OVR_ENABLE      0
`define UPC_OVR_VAL_LSB     1
`define UPC_ST_MODE_LSB     8
`define UPC_ST_PSTATE       11
`define UPC_ST_SWITCH       12
`define UPC_ST_ILIM_LSB     16
`define UPC_ILIM_W          4

// ==========================================================================
// Reset values and counts
`define UPC_RST_OVERRIDE    5'h00
`define UPC_RST_ILIM_MAX    4'hf
`define UPC_RST_ILIM_REQ    4'hf
`define UPC_POL_WAIT        2'h3

`endif

// [rtl/upc_pkg.sv]
/*
 * Types shared by the port power mode controller.
 * Assumes upc_cfg.svh is on the include path.
 */
`include "upc_cfg.svh"

package upc_pkg;
   // ========================================================================
   // Operating modes decoded from the three mode pins
   typedef enum logic [2:0] {
      UPC_MODE_IDLE = 3'b000,
      UPC_MODE_DCE  = 3'b001,
      UPC_MODE_PASS = 3'b010,
      UPC_MODE_DCP  = 3'b011,
      UPC_MODE_SDP  = 3'b100,
      UPC_MODE_CDP  = 3'b101
   } upc_mode_t;

   // ========================================================================
   // Port power states
   typedef enum logic [0:0] {
      UPC_PS_DETECT = 1'b0,
      UPC_PS_ACTIVE = 1'b1
   } upc_pstate_t;

   typedef logic [`UPC_ILIM_W-1:0] upc_ilim_t;
endpackage

// [rtl/upc_top.sv]
/*
 * Port power mode controller: mode decode, power switch gating, attach
 * state machine, pin override and an Avalon-MM register slave.
 * Assumes pins arrive asynchronously and one 50 MHz clock drives all logic.
 */
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
// Notes on behaviour
// - Mode pins 001/101 emulation, 010/110 pass-through, 011 DCP, 100 SDP, 111 CDP.
// - Polarity pin captured once after power-up, held, never overridden.
// - Power switch closes only when enable level equals captured polarity.
// - Alert and attach outputs go low while their condition holds, else high.
// - Override replaces register copies of enable and mode pins; pins unchanged.
// - Attach in Detect with the switch closed moves to Active, applies emulation in DCE mode only and delivers current.
// - Removal returns to Detect and stops charging current.
// - Present current limit exceeds programmed maximum only in the one cycle after the maximum is lowered.
// - Registers keep contents between bus accesses; only reset restores defaults.
// - Pass-through applies no emulation, closes data switch, supplies current.
`timescale 1ns/100ps
`default_nettype none
`include "upc_cfg.svh"

module upc_top (
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_resetn,
   input  wire logic [`UPC_ADDR_W-1:0] i_avs_address,
   input  wire logic                   i_avs_read,
   input  wire logic                   i_avs_write,
   input  wire logic [31:0]            i_avs_writedata,
   output logic [31:0]                 o_avs_readdata,
   output logic                        o_avs_waitrequest,
   input  wire logic                   i_port_power_enable,
   input  wire logic                   i_mode_select_one,
   input  wire logic                   i_mode_select_two,
   input  wire logic                   i_emulation_enable_pin,
   input  wire logic                   i_polarity_select,
   input  wire logic                   i_attach_sense,
   input  wire logic                   i_alert_cond,
   output logic                        o_power_switch_on,
   output logic                        o_fault_notify_n,
   output logic                        o_device_present_n,
   output logic                        o_hs_switch_close,
   output logic                        o_emulation_on,
   output logic                        o_charge_on,
   output upc_pkg::upc_mode_t          o_op_mode,
   output upc_pkg::upc_pstate_t        o_power_state,
   output upc_pkg::upc_ilim_t          o_ilim_present
);
   import upc_pkg::*;

   // =======================================================================
   // Functions
   // Mode pin triple {one, two, emu} to operating mode
   function automatic upc_mode_t mode_decode(input logic [2:0] pins);
      case (pins)
         3'b001, 3'b101: mode_decode = UPC_MODE_DCE;
         3'b010, 3'b110: mode_decode = UPC_MODE_PASS;
         3'b011:         mode_decode = UPC_MODE_DCP;
         3'b100:         mode_decode = UPC_MODE_SDP;
         3'b111:         mode_decode = UPC_MODE_CDP;
         default:        mode_decode = UPC_MODE_IDLE;
      endcase
   endfunction

   function automatic upc_ilim_t ilim_min(input upc_ilim_t a, input upc_ilim_t b);
      ilim_min = (a < b) ? a : b;
   endfunction

   // =======================================================================
   // Pin synchronisers
   logic [`UPC_PIN_W-1:0] pin_meta_r;
   logic [`UPC_PIN_W-1:0] pin_sync_r;
   logic [`UPC_PIN_W-1:0] pin_raw;

   assign pin_raw = {i_alert_cond, i_attach_sense, i_polarity_select,
                     i_emulation_enable_pin, i_mode_select_two,
                     i_mode_select_one, i_port_power_enable};

   // Two flops per pin; only the second stage is read by logic
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
      end else begin
         pin_meta_r <= pin_raw;
         pin_sync_r <= pin_meta_r;
      end
   end

   // =======================================================================
   // Polarity capture: waits until the synchroniser holds a real sample
   logic [1:0] pol_wait_r;
   logic       pol_done_r;
   logic       polarity_r;

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pol_wait_r <= 2'h0;
         pol_done_r <= 1'b0;
         polarity_r <= 1'b0;
      end else if (!pol_done_r) begin
         if (pol_wait_r == `UPC_POL_WAIT) begin
            polarity_r <= pin_sync_r[`UPC_PIN_POLARITY];
            pol_done_r <= 1'b1;
         end else begin
            pol_wait_r <= pol_wait_r + 2'h1;
         end
      end
   end

   // =======================================================================
   // Registers
   logic [4:0]            override_r;   // {emu, two, one, pwr, enable}
   upc_ilim_t             ilim_max_r;
   upc_ilim_t             ilim_req_r;
   logic [`UPC_PIN_W-1:0] pin_copy_r;
   logic                  ack_r;
   logic                  wr_take;
   logic                  rd_take;

   // One wait cycle per access; a write is taken when ack_r is high, a read when it is low
   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
   assign wr_take           = i_avs_write & ack_r;
   assign rd_take           = i_avs_read & ~ack_r;

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
      end
   end

   // Writable registers hold their value with no bus traffic
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         override_r <= `UPC_RST_OVERRIDE;
         ilim_max_r <= `UPC_RST_ILIM_MAX;
         ilim_req_r <= `UPC_RST_ILIM_REQ;
      end else if (wr_take) begin
         case (i_avs_address)
            `UPC_OFS_OVERRIDE: override_r <= i_avs_writedata[4:0];
            `UPC_OFS_ILIM_MAX: ilim_max_r <= i_avs_writedata[`UPC_ILIM_W-1:0];
            `UPC_OFS_ILIM_REQ: ilim_req_r <= i_avs_writedata[`UPC_ILIM_W-1:0];
            default: ;
         endcase
      end
   end

   // Pin copies follow the pins (polarity bit the captured value); enable and mode bits take the override values when enabled
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pin_copy_r <= '0;
      end else begin
         pin_copy_r <= pin_sync_r;
         pin_copy_r[`UPC_PIN_POLARITY] <= polarity_r;
         if (override_r[`UPC_OVR_ENABLE]) begin
            pin_copy_r[`UPC_PIN_EMU_EN:`UPC_PIN_PORT_POWER_ENABLE] <=
               override_r[4:`UPC_OVR_VAL_LSB];
         end
      end
   end

   // =======================================================================
   // Mode decode and power state
   upc_mode_t   mode;
   upc_pstate_t pstate_r;
   upc_pstate_t pstate_nxt;
   logic        switch_ok;

   assign mode = mode_decode({pin_copy_r[`UPC_PIN_MODE1], pin_copy_r[`UPC_PIN_MODE2],
                              pin_copy_r[`UPC_PIN_EMU_EN]});
   // Enable must equal the captured polarity; none before capture is done
   assign switch_ok = pol_done_r & (pin_copy_r[`UPC_PIN_PORT_POWER_ENABLE] == polarity_r);

   // Attach moves Detect to Active; removal or switch opening falls back
   always_comb begin
      pstate_nxt = pstate_r;
      case (pstate_r)
         UPC_PS_DETECT: begin
            if (pin_copy_r[`UPC_PIN_ATTACH] && switch_ok) begin
               pstate_nxt = UPC_PS_ACTIVE;
            end
         end
         UPC_PS_ACTIVE: begin
            if (!pin_copy_r[`UPC_PIN_ATTACH] || !switch_ok) begin
               pstate_nxt = UPC_PS_DETECT;
            end
         end
         default: pstate_nxt = UPC_PS_DETECT;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pstate_r <= UPC_PS_DETECT;
      end else begin
         pstate_r <= pstate_nxt;
      end
   end

   // =======================================================================
   // Registered outputs
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_power_switch_on  <= 1'b0;
         o_fault_notify_n   <= 1'b1;
         o_device_present_n <= 1'b1;
         o_hs_switch_close  <= 1'b0;
         o_emulation_on     <= 1'b0;
         o_charge_on        <= 1'b0;
         o_op_mode          <= UPC_MODE_IDLE;
         o_power_state      <= UPC_PS_DETECT;
         o_ilim_present     <= '0;
      end else begin
         o_power_switch_on  <= switch_ok;
         o_fault_notify_n   <= ~pin_copy_r[`UPC_PIN_ALERT];
         o_device_present_n <= ~pin_copy_r[`UPC_PIN_ATTACH];
         o_hs_switch_close  <= (mode == UPC_MODE_PASS);
         // Emulation only in Active and never in pass-through
         o_emulation_on     <= (pstate_r == UPC_PS_ACTIVE) &&
                               (mode == UPC_MODE_DCE);
         o_charge_on        <= (pstate_r == UPC_PS_ACTIVE) && switch_ok;
         o_op_mode          <= mode;
         o_power_state      <= pstate_r;
         o_ilim_present     <= ilim_min(ilim_req_r, ilim_max_r);
      end
   end

   // =======================================================================
   // Read data, loaded at the edge that ends the wait cycle
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_avs_readdata <= '0;
      end else if (rd_take) begin
         o_avs_readdata <= '0;
         case (i_avs_address)
            `UPC_OFS_PIN_STATE: begin
               o_avs_readdata[`UPC_PIN_W-1:0] <= pin_copy_r;
               o_avs_readdata[`UPC_ST_MODE_LSB +: 3] <= mode;
               o_avs_readdata[`UPC_ST_PSTATE]  <= pstate_r;
               o_avs_readdata[`UPC_ST_SWITCH]  <= switch_ok;
               o_avs_readdata[`UPC_ST_ILIM_LSB +: `UPC_ILIM_W] <= o_ilim_present;
            end
            `UPC_OFS_OVERRIDE: o_avs_readdata[4:0] <= override_r;
            `UPC_OFS_ILIM_MAX: o_avs_readdata[`UPC_ILIM_W-1:0] <= ilim_max_r;
            `UPC_OFS_ILIM_REQ: o_avs_readdata[`UPC_ILIM_W-1:0] <= ilim_req_r;
            default: ;
         endcase
      end
   end

   // =======================================================================
   // Assertions
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);

   AST_MODE_PASS: assert property (
      ({pin_copy_r[1], pin_copy_r[2], pin_copy_r[3]} == 3'b110)
      |=> o_op_mode == UPC_MODE_PASS)
      else $error("mode 110 not decoded as pass-through");
   AST_MODE_CDP: assert property (
      (&pin_copy_r[3:1]) |=> o_op_mode == UPC_MODE_CDP)
      else $error("mode 111 not decoded as CDP");
   AST_POL_HELD: assert property (
      pol_done_r |=> $stable(polarity_r) && pol_done_r)
      else $error("captured polarity changed");
   AST_SWITCH: assert property (
      o_power_switch_on |-> $past(pin_copy_r[0]) == polarity_r)
      else $error("switch closed with mismatched enable");
   AST_PRESENT: assert property (
      pin_sync_r[5] && !override_r[0] |-> ##2 !o_device_present_n)
      else $error("attach output not low");
   AST_FAULT: assert property (
      !pin_copy_r[6] |=> o_fault_notify_n)
      else $error("alert output low without alert");
   AST_OVR: assert property (
      override_r[0] |=> pin_copy_r[3:0] == $past(override_r[4:1]))
      else $error("override values not applied");
   AST_ACTIVE: assert property (
      pstate_r == UPC_PS_DETECT && pin_copy_r[5] && switch_ok
      |=> pstate_r == UPC_PS_ACTIVE)
      else $error("attach did not enter Active");
   AST_REMOVE: assert property (
      pstate_r == UPC_PS_ACTIVE && !pin_copy_r[5]
      |=> pstate_r == UPC_PS_DETECT ##1 !o_charge_on)
      else $error("removal did not stop charging");
   AST_ILIM: assert property (
      o_ilim_present <= ilim_max_r || $changed(ilim_max_r) || $past(wr_take))
      else $error("present limit above maximum");
   AST_HOLD: assert property (
      !wr_take |=> $stable(ilim_max_r) && $stable(override_r))
      else $error("register changed without a write");
   AST_PASS_NOEMU: assert property (
      o_hs_switch_close |-> !o_emulation_on)
      else $error("emulation during pass-through");

   COV_ACTIVE:   cover property (pstate_r == UPC_PS_ACTIVE && o_emulation_on);
   COV_REMOVE:   cover property (pstate_r == UPC_PS_ACTIVE ##1 pstate_r == UPC_PS_DETECT);
   COV_OVERRIDE: cover property (override_r[0] && wr_take);
   COV_PASS:     cover property (o_hs_switch_close && o_charge_on);
endmodule
`default_nettype wire

// [testbench/testbench.sv]
/*
 * Self-checking bench for the port power mode controller: Avalon-MM
 * tasks, pin stimulus and a device model on the port.
 * Assumes the design answers each access after one wait cycle.
 */
`timescale 1ns/100ps
`default_nettype none
`include "upc_cfg.svh"

module testbench;
   import upc_pkg::*;
   logic             clk, rstn, rd, wr, pwr, pol, plug, ovd;
   logic [3:0]       adr;
   logic [31:0]      wdat, rdat, v;
   logic [2:0]       mp;
   logic             wait_n, sw, flt_n, pres_n, hs, emu, chg, att, alr;
   upc_mode_t        mode;
   upc_pstate_t      ps;
   upc_ilim_t        ilim;
   int               err_total, comparisons, cyc;

   upc_top upc_top_i (.i_sys_clk(clk), .i_resetn(rstn), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
      .o_avs_readdata(rdat), .o_avs_waitrequest(wait_n),
      .i_port_power_enable(pwr), .i_mode_select_one(mp[2]),
      .i_mode_select_two(mp[1]), .i_emulation_enable_pin(mp[0]),
      .i_polarity_select(pol), .i_attach_sense(att), .i_alert_cond(alr),
      .o_power_switch_on(sw), .o_fault_notify_n(flt_n),
      .o_device_present_n(pres_n), .o_hs_switch_close(hs), .o_emulation_on(emu),
      .o_charge_on(chg), .o_op_mode(mode), .o_power_state(ps), .o_ilim_present(ilim));

   upc_dev_model upc_dev_model_i (.i_sys_clk(clk), .i_plug(plug), .i_overdraw(ovd),
      .i_charge_on(chg), .o_attach_sense(att), .o_alert_cond(alr));

   // ======================================================================
   // Clock, and a ceiling well above the few hundred cycles needed
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         results();
      end
   end

   task automatic results();
      if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ======================================================================
   // Bus tasks: entered just after an edge, request held until waitrequest
   // is seen low mid-cycle; the rising edge after that also carries the read data.
   // Waitrequest is read mid-cycle, where it has settled, so the edge that
   // ends the access is never confused with the one that launches it.
   task automatic av_acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      logic ws;
      ws = 1'b1;
      adr <= a;
      wdat <= d;
      if (w) wr <= 1'b1;
      else rd <= 1'b1;
      while (ws) begin
         @(negedge clk);
         ws = (wait_n !== 1'b0);
         @(posedge clk);
      end
      v = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      // Idle edge so a following call never re-raises a strobe in this step
      @(posedge clk);
   endtask

   task automatic do_reset(input logic p);
      pol <= p;
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (6) @(posedge clk); // Polarity capture lands 4 edges after release
   endtask

   // Model flop, 2 sync flops, copy, state and outputs: up to 6 edges, and
   // outputs are read only after the edge that launched them has passed
   task automatic settle();
      repeat (8) @(posedge clk);
   endtask

   function automatic upc_mode_t exp_mode(input logic [2:0] m);
      case (m)
         3'b001, 3'b101: return UPC_MODE_DCE;
         3'b010, 3'b110: return UPC_MODE_PASS;
         3'b011:         return UPC_MODE_DCP;
         3'b100:         return UPC_MODE_SDP;
         3'b111:         return UPC_MODE_CDP;
         default:        return UPC_MODE_IDLE;
      endcase
   endfunction

   // ======================================================================
   // Main sequence
   initial begin
      rstn = 1'b0; rd = 1'b0; wr = 1'b0; adr = 4'h0; wdat = 32'h0;
      pwr = 1'b1; pol = 1'b1; plug = 1'b0; ovd = 1'b0; mp = 3'b001;
      err_total = 0; comparisons = 0; cyc = 0;
      @(posedge clk);
      do_reset(1'b1);
      // Reset defaults and an unmapped place
      av_acc(1'b0, `UPC_OFS_OVERRIDE, 32'h0); chk(v, 32'h0);
      av_acc(1'b0, `UPC_OFS_ILIM_MAX, 32'h0); chk(v, 32'hf);
      av_acc(1'b0, `UPC_OFS_ILIM_REQ, 32'h0); chk(v, 32'hf);
      av_acc(1'b1, 4'h1, 32'h5);
      av_acc(1'b0, 4'h1, 32'h0); chk(v, 32'h0);
      chk({pres_n, flt_n}, 2'b11);
      // Every mode pin combination, with its register copy
      for (int m = 0; m < 8; m++) begin
         mp <= 3'(m);
         settle();
         chk(mode, exp_mode(3'(m)));
         chk(hs, exp_mode(3'(m)) == UPC_MODE_PASS);
         av_acc(1'b0, `UPC_OFS_PIN_STATE, 32'h0);
         chk(v[3:0], {mp[0], mp[1], mp[2], 1'b1});
      end
      // Attach, overload, then removal with an emulation mode selected
      mp <= 3'b001;
      plug <= 1'b1;
      settle();
      chk({pres_n, ps, chg, emu}, {1'b0, UPC_PS_ACTIVE, 2'b11});
      ovd <= 1'b1;
      settle();
      chk(flt_n, 1'b0);
      ovd <= 1'b0;
      plug <= 1'b0;
      settle();
      chk({pres_n, flt_n, ps, chg}, {2'b11, UPC_PS_DETECT, 1'b0});
      // Enable against the polarity latched at power-up
      pwr <= 1'b0;
      settle();
      chk(sw, 1'b0);
      pol <= 1'b0;
      settle();
      chk(sw, 1'b0);
      pol <= 1'b1;
      pwr <= 1'b1;
      settle();
      chk(sw, 1'b1);
      // Override forces pass-through with the enable low
      av_acc(1'b1, `UPC_OFS_OVERRIDE, 32'h9);
      settle();
      chk({mode, hs, sw}, {UPC_MODE_PASS, 2'b10});
      av_acc(1'b0, `UPC_OFS_PIN_STATE, 32'h0); chk(v[3:0], 4'h4);
      av_acc(1'b0, `UPC_OFS_OVERRIDE, 32'h0); chk(v, 32'h9);
      av_acc(1'b1, `UPC_OFS_OVERRIDE, 32'h0);
      settle();
      chk({mode, sw}, {UPC_MODE_DCE, 1'b1});
      // Present limit clamped by the maximum
      av_acc(1'b1, `UPC_OFS_ILIM_MAX, 32'h3);
      repeat (2) @(posedge clk);
      chk(ilim, 4'h3);
      av_acc(1'b1, `UPC_OFS_ILIM_REQ, 32'h2);
      av_acc(1'b1, `UPC_OFS_ILIM_MAX, 32'h1);
      repeat (2) @(posedge clk);
      chk(ilim, 4'h1);
      av_acc(1'b0, `UPC_OFS_PIN_STATE, 32'h0); chk(v[19:16], 4'h1);
      // Silent bus keeps contents; only reset restores them
      repeat (200) @(posedge clk);
      av_acc(1'b0, `UPC_OFS_ILIM_REQ, 32'h0); chk(v, 32'h2);
      do_reset(1'b0);
      av_acc(1'b0, `UPC_OFS_ILIM_MAX, 32'h0); chk(v, 32'hf);
      av_acc(1'b0, `UPC_OFS_ILIM_REQ, 32'h0); chk(v, 32'hf);
      pwr <= 1'b0;
      settle();
      chk(sw, 1'b1);
      results();
   end
endmodule

`default_nettype wire

// [testbench/upc_dev_model.sv]
/*
 * Behavioural portable device on the charging port: plugs in and out on
 * command and can draw too much current while charge is delivered.
 * Assumes the bench commands plug and overdraw and feeds back charge_on.
 */
`timescale 1ns/100ps
`default_nettype none

module upc_dev_model (
   input  wire logic i_sys_clk,
   input  wire logic i_plug,
   input  wire logic i_overdraw,
   input  wire logic i_charge_on,
   output logic      o_attach_sense,
   output logic      o_alert_cond
);
   // ======================================================================
   // Sense follows the plug; a removed device leaves the sense pulled low
   always_ff @(posedge i_sys_clk) begin
      o_attach_sense <= i_plug;
   end

   // Overload only shows while the port really delivers current
   always_ff @(posedge i_sys_clk) begin
      o_alert_cond <= i_plug & i_overdraw & i_charge_on;
   end
endmodule

`default_nettype wire
